// [include/la_capture_pkg.sv]
// How it works
// - Latch all sixteen data lines together
// - Trigger comparator runs free, even unarmed
// - Edge select inverts or passes clock
// - Qualified pulse only when qualifier matches
// - Qualified pulse ends itself after 4 cycles, 100 ns
// - Trigger needs all contributors true together
// - Arming forces trigger low first
// - Trigger qualifier high, low or ignored
// - Four enabled hex digits compared
// - Trigger disarms; 63 more cycles recorded
// - Memory is two 128x8 arrays
// - Record mode blanks displays, stops strobe
// - Qualified record edge advances address, writes unless last
// - Replay reads memory on internal clock
// - Arm records; completion or abort replays
// - Armed holds 64; trigger counts to 128
// - Replay counts 0 to 192 repeatedly
// - At 64 cursor counts up, trigger mark
// - At 192 reset, preload 64, sync pulse
// - Strobe on inverse cursor match, not flyback
// - Decimal cursor 64 down 0, up 63
// - Channel step counter advances at 128
package la_capture_pkg;

  // ==========================================================
  // Register map, byte addresses
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Edge, qualifiers, digit enables
  localparam logic [7:0] ADDR_WORD = 8'h04; // Trigger word, four hex digits
  localparam logic [7:0] ADDR_CMD = 8'h08; // Arm and abort, write only
  localparam logic [7:0] ADDR_CURSOR = 8'h0C; // Cursor counter value
  localparam logic [7:0] ADDR_STATUS = 8'h10; // Mode, armed, counters
  localparam logic [7:0] ADDR_DISP = 8'h14; // Display latches

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_ABORT_BIT = 1;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] CURSOR_RESET = 8'hBF; // Inverse of 64: trigger word

  // Qualifier level codes
  localparam logic [1:0] QUAL_ANY = 2'h0; // Don't care
  localparam logic [1:0] QUAL_HIGH = 2'h1;
  localparam logic [1:0] QUAL_LOW = 2'h2;

  // ==========================================================
  // Counter landmarks
  // ==========================================================
  localparam logic [7:0] CYC_ARMED = 8'h40; // 64
  localparam logic [7:0] CYC_LAST_REC = 8'h7F; // 127
  localparam logic [7:0] CYC_STOP = 8'h80; // 128
  localparam logic [7:0] CYC_LAST = 8'hC0; // 192
  localparam logic [7:0] CURPOS_PRELOAD = 8'h64; // Decimal 64 in BCD

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 40;
  localparam int QPULSE_NS = 80;
  // Least time, rounded up to whole cycles
  localparam int QPULSE_CYC = (QPULSE_NS * CLK_MHZ + 999) / 1000;

  // Operating mode
  typedef enum logic {MODE_REPLAY, MODE_RECORD} mode_e;

  // Configuration bits as one carrier
  typedef struct packed {
    logic [3:0] dig_en; // Digit enables, digit 3 on the left
    logic [1:0] tq_mode; // Trigger qualifier level
    logic [1:0] cq_mode; // Clock qualifier level
    logic edge_fall; // Capture on falling edge
  } cfg_s;

endpackage : la_capture_pkg

// [rtl/la_capture.sv]
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module la_capture
  import la_capture_pkg::*;
#(
  parameter int REPLAY_DIV = 40 // Core cycles per internal replay tick
)(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ext_clk, // Clock from the system under test
  input wire logic i_clk_qual, // Clock qualifier pin
  input wire logic i_trig_qual, // Trigger qualifier pin
  input wire logic [15:0] i_data, // Data pins
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_trig_match_n, // Low while the trigger condition holds
  output logic [15:0] o_disp_data, // Data display latch
  output logic [7:0] o_disp_cursor, // Cursor display, two BCD digits
  output logic o_disp_sign, // Cursor sign, high for plus
  output logic o_disp_blank, // Blank all displays
  output logic o_cursor_mark, // One pulse per display strobe
  output logic o_trig_mark, // High at the trigger position
  output logic o_sweep_sync, // Pulse at end of each replay sweep
  output logic o_lsb_serial, // Selected low byte channel
  output logic o_msb_serial, // Selected high byte channel
  output logic [2:0] o_chan_sel, // Channel being shown
  output logic o_recording // Record mode
);

  // Assertion defaults for this single clock domain
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [18:0] pin_s1_q; // First stage, read only by second
  logic [18:0] pin_s2_q; // Second stage
  logic clk_s3_q; // Previous clock sample for edge finding

  // Two flops on every pin, one extra on the clock
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_s1_q <= 19'h00000;
      pin_s2_q <= 19'h00000;
      clk_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {i_ext_clk, i_clk_qual, i_trig_qual, i_data};
      pin_s2_q <= pin_s1_q;
      clk_s3_q <= pin_s2_q[18];
    end
  end

  wire logic [15:0] data_s = pin_s2_q[15:0];
  wire logic tq_s = pin_s2_q[16];
  wire logic cq_s = pin_s2_q[17];

  // ==========================================================
  // Registers
  // ==========================================================
  cfg_s cfg_q; // Configuration
  logic [15:0] tword_q; // Trigger word
  logic [7:0] cursor_q; // Cursor counter

  wire logic sel_ctrl = (i_addr == ADDR_CTRL);
  wire logic sel_word = (i_addr == ADDR_WORD);
  wire logic sel_cmd = (i_addr == ADDR_CMD);
  wire logic sel_cursor = (i_addr == ADDR_CURSOR);
  wire logic sel_status = (i_addr == ADDR_STATUS);
  wire logic sel_disp = (i_addr == ADDR_DISP);
  wire logic arm_cmd = i_wr && sel_cmd && i_wdata[CMD_ARM_BIT];
  wire logic abort_cmd = i_wr && sel_cmd && i_wdata[CMD_ABORT_BIT];

  // Software writable state
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_q <= CTRL_RESET;
      tword_q <= WORD_RESET;
      cursor_q <= CURSOR_RESET;
    end
    else if (i_wr)
    begin
      if (sel_ctrl)
        cfg_q <= i_wdata[8:0];
      if (sel_word)
        tword_q <= i_wdata[15:0];
      if (sel_cursor)
        cursor_q <= i_wdata[7:0];
    end
  end

  // ==========================================================
  // Qualified clock
  // ==========================================================
  logic qpulse_q; // Self clearing pulse latch
  logic [3:0] qcnt_q; // Cycles left in the pulse

  // Edge choice by inverting or passing the clock
  wire logic sel_clk = pin_s2_q[18] ^ cfg_q.edge_fall;
  wire logic sel_prev = clk_s3_q ^ cfg_q.edge_fall;
  wire logic clk_rise = sel_clk && !sel_prev;
  wire logic cq_ok = (cfg_q.cq_mode == QUAL_ANY) ||
                     ((cfg_q.cq_mode == QUAL_HIGH) && cq_s) ||
                     ((cfg_q.cq_mode == QUAL_LOW) && !cq_s);
  // Edges landing inside a pulse are lost, like the latch
  wire logic qstart = clk_rise && cq_ok && !qpulse_q;

  // Pulse sets on a qualified edge, clears itself
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      qpulse_q <= 1'b0;
      qcnt_q <= 4'h0;
    end
    else if (qstart)
    begin
      qpulse_q <= 1'b1;
      qcnt_q <= 4'(QPULSE_CYC - 1);
    end
    else if (qpulse_q)
    begin
      if (qcnt_q == 4'h0)
        qpulse_q <= 1'b0;
      else
        qcnt_q <= qcnt_q - 4'h1;
    end
  end

  pulse_len_a: assert property ($rose(qpulse_q) |-> qpulse_q[*4] ##1 !qpulse_q)
    else $error("qualified pulse length wrong");
  pulse_qual_a: assert property ($rose(qpulse_q) |-> $past(cq_ok) && $past(clk_rise))
    else $error("pulse without qualified edge");

  // ==========================================================
  // Input latches and trigger comparator
  // ==========================================================
  logic [15:0] word_q; // Latched data word
  logic tq_q; // Latched trigger qualifier

  // All lines latch in one step so the comparator sees one change
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      word_q <= 16'h0000;
      tq_q <= 1'b0;
    end
    else if (qstart)
    begin
      word_q <= data_s;
      tq_q <= tq_s;
    end
  end

  latch_all_a: assert property (qstart |=> word_q == $past(data_s))
    else $error("data latch missed a word");

  logic [3:0] dig_ok;
  // Per digit compare, disabled digits pass
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_digit
      assign dig_ok[g] = !cfg_q.dig_en[g] || (word_q[4*g +: 4] == tword_q[4*g +: 4]);
    end
  endgenerate

  wire logic tq_ok = (cfg_q.tq_mode == QUAL_ANY) ||
                     ((cfg_q.tq_mode == QUAL_HIGH) && tq_q) ||
                     ((cfg_q.tq_mode == QUAL_LOW) && !tq_q);
  logic arm_hold_q; // Holds the trigger bus low after arming
  // Wired AND of every contributor
  wire logic trig_cond = tq_ok && (&dig_ok) && !arm_hold_q;
  logic trig_prev_q; // Last trigger bus level
  wire logic trig_edge = trig_cond && !trig_prev_q;

  // ==========================================================
  // Control: mode, cycle counter, address, memory
  // ==========================================================
  mode_e mode_q;
  logic armed_q;
  logic [7:0] cyc_q; // Cycle counter
  logic [6:0] addr_q; // Memory address counter
  logic [7:0] mem_lo [128]; // Low byte array
  logic [7:0] mem_hi [128]; // High byte array
  logic [11:0] step_q; // Channel step counter
  logic [7:0] curpos_q; // Decimal cursor position
  logic sweep_q;
  logic [6:0] div_q; // Replay tick divider
  logic tick_q; // Internal replay clock enable

  wire logic recording = (mode_q == MODE_RECORD);
  wire logic rec_arm = recording && armed_q && qstart;
  wire logic rec_post = recording && !armed_q && qstart;
  wire logic rec_done = rec_post && (cyc_q == CYC_LAST_REC);
  wire logic mem_we = rec_arm || (rec_post && !rec_done);
  wire logic rep_tick = !recording && tick_q;
  wire logic [7:0] cyc_nxt = cyc_q + 8'h01;
  wire logic [6:0] addr_nxt = addr_q + 7'h01;
  wire logic [15:0] rd_word = {mem_hi[addr_q], mem_lo[addr_q]};

  // Internal clock as an enable pulse
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == 7'(REPLAY_DIV - 1));
      div_q <= (div_q == 7'(REPLAY_DIV - 1)) ? 7'h00 : div_q + 7'h01;
    end
  end

  // Writes at the freshly advanced address, both bytes at once
  always_ff @(posedge i_core_clk)
  begin
    if (mem_we)
    begin
      mem_lo[addr_nxt] <= data_s[7:0];
      mem_hi[addr_nxt] <= data_s[15:8];
    end
  end

  // Mode, arm and trigger latch
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mode_q <= MODE_REPLAY;
      armed_q <= 1'b0;
      arm_hold_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_cond;
      arm_hold_q <= arm_cmd && !abort_cmd;
      if (abort_cmd)
      begin
        mode_q <= MODE_REPLAY;
        armed_q <= 1'b0;
      end
      else if (arm_cmd)
      begin
        mode_q <= MODE_RECORD;
        armed_q <= 1'b1;
      end
      else
      begin
        if (armed_q && trig_edge)
          armed_q <= 1'b0;
        if (rec_done)
          mode_q <= MODE_REPLAY;
      end
    end
  end

  arm_low_a: assert property (arm_cmd && !abort_cmd |=> !trig_cond)
    else $error("trigger not held low after arm");
  disarm_a: assert property (armed_q && !arm_cmd && trig_edge |=> !armed_q)
    else $error("trigger edge did not disarm");

  // Cycle counter, address counter, cursor position, channel step
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cyc_q <= 8'h00;
      addr_q <= 7'h00;
      curpos_q <= CURPOS_PRELOAD;
      step_q <= 12'h000;
      sweep_q <= 1'b0;
    end
    else
    begin
      sweep_q <= 1'b0;
      if (arm_cmd && !abort_cmd)
        cyc_q <= CYC_ARMED;
      else if (rec_arm)
      begin
        cyc_q <= CYC_ARMED;
        addr_q <= addr_nxt;
      end
      else if (rec_done)
      begin
        cyc_q <= CYC_STOP;
        // Step past the newest word so each sweep opens on the oldest
        addr_q <= addr_nxt;
      end
      else if (rec_post)
      begin
        cyc_q <= cyc_nxt;
        addr_q <= addr_nxt;
      end
      else if (rep_tick)
      begin
        if (cyc_q == CYC_LAST)
        begin
          cyc_q <= 8'h00;
          curpos_q <= CURPOS_PRELOAD;
          sweep_q <= 1'b1;
        end
        else
        begin
          cyc_q <= cyc_nxt;
          curpos_q <= (cyc_nxt <= CYC_ARMED) ? bcd_dec(curpos_q) : bcd_inc(curpos_q);
        end
        if (!cyc_q[7])
          addr_q <= addr_nxt;
        if (cyc_nxt == CYC_STOP)
          step_q <= step_q + 12'h001;
      end
    end
  end

  armed_hold_a: assert property (recording && armed_q |-> cyc_q == 8'h40)
    else $error("cycle counter not held at 64");
  rec_end_a: assert property (rec_done && !arm_cmd && !abort_cmd
                              |=> !recording && cyc_q == 8'h80)
    else $error("record did not end at 128");
  sweep_wrap_a: assert property (rep_tick && cyc_q == 8'hC0 && !arm_cmd
                                 |=> cyc_q == 8'h00 && sweep_q && curpos_q == 8'h64)
    else $error("sweep end handling wrong");
  rec_stop_a: assert property (mem_we |-> recording && !cyc_q[7])
    else $error("write after record end");

  // Two digit decimal step down, with floor at zero
  function automatic logic [7:0] bcd_dec(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v == 8'h00)
      r = 8'h00;
    else if (v[3:0] == 4'h0)
      r = {v[7:4] - 4'h1, 4'h9};
    else
      r = {v[7:4], v[3:0] - 4'h1};
    return r;
  endfunction : bcd_dec

  // Two digit decimal step up, wrapping at 99
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v == 8'h99)
      r = 8'h00;
    else if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, 4'h0};
    else
      r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_inc

  // ==========================================================
  // Cursor compare and display outputs
  // ==========================================================
  logic hit_prev_q;
  // Match on inverse bits; bit 7 of the count marks flyback
  wire logic cur_hit = !recording && (cyc_q == ~cursor_q) && !cyc_q[7];
  wire logic strobe = cur_hit && !hit_prev_q;

  // Display latches and scope markers
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hit_prev_q <= 1'b0;
      o_disp_data <= 16'h0000;
      o_disp_cursor <= 8'h00;
      o_disp_sign <= 1'b0;
      o_disp_blank <= 1'b1;
      o_cursor_mark <= 1'b0;
      o_trig_mark <= 1'b0;
      o_sweep_sync <= 1'b0;
      o_lsb_serial <= 1'b0;
      o_msb_serial <= 1'b0;
      o_chan_sel <= 3'h0;
      o_recording <= 1'b0;
      o_trig_match_n <= 1'b1;
    end
    else
    begin
      hit_prev_q <= cur_hit;
      o_cursor_mark <= strobe;
      if (strobe)
      begin
        o_disp_data <= rd_word;
        o_disp_cursor <= curpos_q;
        o_disp_sign <= (cyc_q >= CYC_ARMED);
      end
      o_disp_blank <= recording;
      o_trig_mark <= (cyc_q == CYC_ARMED) && !recording;
      o_sweep_sync <= sweep_q;
      o_chan_sel <= step_q[2:0];
      o_lsb_serial <= rd_word[step_q[2:0]];
      o_msb_serial <= rd_word[4'h8 + {1'b0, step_q[2:0]}];
      o_recording <= recording;
      o_trig_match_n <= !trig_cond;
    end
  end

  blank_a: assert property (recording |=> o_disp_blank && !o_cursor_mark)
    else $error("display active while recording");
  no_fly_a: assert property (o_cursor_mark |-> !$past(cyc_q[7]))
    else $error("strobe during flyback");
  trig_out_a: assert property (!armed_q && trig_cond |=> !o_trig_match_n)
    else $error("trigger output missing while unarmed");

  // ==========================================================
  // Read port, data one cycle after the strobe
  // ==========================================================
  wire logic [31:0] status_word = {15'h0000, addr_q, cyc_q, armed_q, recording};
  wire logic [31:0] disp_word = {7'h00, o_disp_sign, o_disp_cursor, o_disp_data};
  wire logic [31:0] rd_mux = sel_ctrl ? {23'h000000, cfg_q} :
                             sel_word ? {16'h0000, tword_q} :
                             sel_cursor ? {24'h000000, cursor_q} :
                             sel_status ? status_word :
                             sel_disp ? disp_word : 32'h00000000;

  // Unmapped and write-only addresses read zero
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 32'h00000000;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 32'h00000000;
  end

endmodule : la_capture

// [verification/sut_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Far side: a clocked system under test
// ==========================================================
module sut_model (
  output logic o_ext_clk, // Capture clock, stands low between frames
  output logic o_clk_qual, // Clock qualifier level
  output logic o_trig_qual, // Trigger qualifier level
  output logic [15:0] o_data // Data pins
);
  // Idle state: released lines sit on their pull-ups
  initial
  begin
    o_ext_clk = 1'b0;
    o_clk_qual = 1'b1;
    o_trig_qual = 1'b1;
    o_data = 16'hFFFF;
  end

  // One 232 ns clock period; dr valid around the rise, df around the fall
  // Data changes mid-high so a wrong edge choice latches the wrong word
  task automatic frame(input logic [15:0] dr, input logic [15:0] df, input logic cq,
    input logic tq);
    #7;
    o_clk_qual = cq;
    o_trig_qual = tq;
    o_data = dr;
    #50 o_ext_clk = 1'b1;
    #50 o_data = df;
    #50 o_ext_clk = 1'b0;
    #50 o_data = 16'hFFFF; // Hold time over: lines float high
    #25;
  endtask : frame
endmodule : sut_model

// [verification/la_capture_bench.sv]
`timescale 1ns/1ps
module la_capture_bench;
  import la_capture_pkg::*;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  localparam int RDIV = 4; // Short replay tick keeps sweeps brief
  localparam int SWEEP = 193 * RDIV; // Core cycles per replay sweep
  localparam int LIMIT = 20000; // Run needs under half of this
  logic i_core_clk;
  logic i_rstn;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic ext_clk, clk_qual, trig_qual;
  logic [15:0] pins;
  logic [31:0] o_rdata;
  logic [15:0] o_disp_data;
  logic [7:0] o_disp_cursor;
  logic [2:0] o_chan_sel;
  logic o_trig_match_n, o_disp_sign, o_disp_blank, o_cursor_mark;
  logic o_trig_mark, o_sweep_sync, o_recording, o_lsb_serial, o_msb_serial;
  int n_errors = 0;
  int checks = 0;
  int seed = 30681;
  int cyc = 0;
  int nm, ns, nt;
  cfg_s c;
  logic [31:0] v, ev;
  logic [15:0] wd, dr, df, lw, base;
  logic [15:0] pre [130];
  logic [15:0] post [63];
  logic [3:0] m;
  logic [6:0] a0;
  logic [2:0] ch;
  logic cqp, tqp, qual, got;

  sut_model i_sut (.o_ext_clk(ext_clk), .o_clk_qual(clk_qual), .o_trig_qual(trig_qual),
    .o_data(pins));

  la_capture #(.REPLAY_DIV(RDIV)) i_dut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ext_clk(ext_clk), .i_clk_qual(clk_qual),
    .i_trig_qual(trig_qual), .i_data(pins), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_trig_match_n(o_trig_match_n),
    .o_disp_data(o_disp_data), .o_disp_cursor(o_disp_cursor), .o_disp_sign(o_disp_sign),
    .o_disp_blank(o_disp_blank), .o_cursor_mark(o_cursor_mark), .o_trig_mark(o_trig_mark),
    .o_sweep_sync(o_sweep_sync), .o_lsb_serial(o_lsb_serial), .o_msb_serial(o_msb_serial),
    .o_chan_sel(o_chan_sel),
    .o_recording(o_recording));

  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // Hang guard: counts as a mismatch, then closes the run
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_errors++;
      $display("FAIL %0t watchdog expired", $time);
      give_verdict();
    end
  end

  // ==========================================================
  // Bus tasks, compares and models
  // ==========================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string what);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %0t %s: got %h want %h", $time, what, g, e);
    end
  endtask : chk32

  task automatic chk1(input logic g, input logic e, input string what);
    chk32({31'h0, g}, {31'h0, e}, what);
  endtask : chk1

  // Comparator model: qualifier level and every enabled hex digit
  function automatic logic exp_match(input cfg_s k, input logic [15:0] w,
    input logic [15:0] l, input logic t);
    logic ok;
    ok = (k.tq_mode == QUAL_ANY) || (k.tq_mode == QUAL_HIGH && t) || (k.tq_mode == QUAL_LOW && !t);
    for (int i = 0; i < 4; i++)
      if (k.dig_en[i] && l[4*i +: 4] != w[4*i +: 4])
        ok = 1'b0;
    return ok;
  endfunction : exp_match

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    i_rstn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    lw = 16'h0000;
    tqp = 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    // Reset values, plus the write-only and unmapped places reading zero
    rd(ADDR_CTRL, v);
    chk32(v, 32'(CTRL_RESET), "ctrl reset");
    rd(ADDR_WORD, v);
    chk32(v, 32'(WORD_RESET), "word reset");
    rd(ADDR_CURSOR, v);
    chk32(v, 32'(CURSOR_RESET), "cursor reset");
    rd(ADDR_CMD, v);
    chk32(v, 32'h0000_0000, "command read");
    rd(8'h18, v);
    chk32(v, 32'h0000_0000, "unmapped read");
    chk1(o_recording, 1'b0, "replay after reset");
    $display("test reset done");

    // Free-running comparator, edge choice and clock qualifier, unarmed
    for (int e = 0; e < 2; e++)
    begin
      for (int n = 0; n < 12; n++)
      begin
        c.edge_fall = e[0];
        // All four level codes, the never-matching one included
        c.cq_mode = (n == 0) ? QUAL_ANY : 2'($random(seed));
        c.tq_mode = 2'($random(seed));
        c.dig_en = 4'($random(seed));
        cqp = 1'($random(seed));
        qual = (c.cq_mode == QUAL_ANY) || (c.cq_mode == QUAL_HIGH && cqp) ||
          (c.cq_mode == QUAL_LOW && !cqp);
        dr = 16'($random(seed));
        df = 16'($random(seed));
        base = qual ? (e[0] ? df : dr) : lw;
        m = 4'($random(seed));
        wd = base ^ (16'($random(seed)) & {{4{m[3]}}, {4{m[2]}}, {4{m[1]}}, {4{m[0]}}});
        // Ignored edges leave latched word and qualifier as they were
        if (qual)
        begin
          lw = base;
          tqp = 1'($random(seed));
        end
        wr(ADDR_CTRL, 32'(c));
        wr(ADDR_WORD, {16'h0000, wd});
        tick(1);
        i_sut.frame(dr, df, cqp, tqp);
        tick(8);
        chk1(o_trig_match_n, !exp_match(c, wd, lw, tqp), "trigger out");
      end
    end
    $display("test comparator done");

    // Record: wrap of pre-trigger writes, trigger, 63 post-trigger words
    wr(ADDR_CTRL, 32'h0000_01E0);
    wr(ADDR_WORD, 32'h0000_1234);
    wr(ADDR_CMD, 32'h0000_0001);
    tick(2);
    chk1(o_recording, 1'b1, "record mode");
    chk1(o_disp_blank, 1'b1, "blank in record");
    rd(ADDR_STATUS, v);
    chk32(v & 32'h0000_03FF, 32'h0000_0103, "armed status");
    a0 = v[16:10];
    for (int k = 0; k < 130; k++)
    begin
      pre[k] = 16'($random(seed));
      if (pre[k] == 16'h1234)
        pre[k] = 16'h1235;
      i_sut.frame(pre[k], pre[k], 1'b1, 1'b1);
    end
    tick(4);
    rd(ADDR_STATUS, v);
    chk32(v & 32'h0001_FFFF, {15'h0, a0 + 7'd2, 8'h40, 2'b11}, "pre status");
    i_sut.frame(16'h1234, 16'h1234, 1'b1, 1'b1);
    tick(4);
    chk1(o_trig_match_n, 1'b0, "trigger on word");
    rd(ADDR_STATUS, v);
    chk32(v & 32'h0000_0003, 32'h0000_0001, "disarmed");
    for (int k = 0; k < 63; k++)
    begin
      post[k] = 16'($random(seed));
      i_sut.frame(post[k], post[k], 1'b1, 1'b1);
    end
    tick(4);
    rd(ADDR_STATUS, v);
    chk32(v & 32'h0001_FFFF, {15'h0, a0 + 7'd66, 8'h7F, 2'b01}, "post status");
    i_sut.frame(16'h0000, 16'h0000, 1'b1, 1'b1);
    tick(4);
    chk1(o_recording, 1'b0, "auto replay");
    chk1(o_disp_blank, 1'b0, "unblank");
    $display("test record done");

    // Replay: oldest word, trigger word and newest word through the cursor
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_CURSOR, {24'h0, ~(k == 0 ? 8'd0 : (k == 1 ? 8'd64 : 8'd127))});
      tick(3);
      got = 1'b0;
      for (int w = 0; w < 2 * SWEEP && !got; w++)
      begin
        @(posedge i_core_clk);
        #1 got = (o_cursor_mark === 1'b1);
      end
      tick(1);
      chk1(got, 1'b1, "strobe");
      wd = k == 0 ? pre[66] : (k == 1 ? 16'h1234 : post[62]);
      ev = {7'h00, k != 0, k == 0 ? 8'h64 : (k == 1 ? 8'h00 : 8'h63), wd};
      chk32({16'h0, o_disp_data}, {16'h0, wd}, "display word");
      chk32({23'h0, o_disp_sign, o_disp_cursor}, {23'h0, ev[24:16]}, "cursor");
      // Serial outputs follow the same word while the address holds
      chk1(o_lsb_serial, wd[o_chan_sel], "low serial");
      chk1(o_msb_serial, wd[{1'b1, o_chan_sel}], "high serial");
      rd(ADDR_DISP, v);
      chk32(v, ev, "display read");
    end
    $display("test replay done");

    // Cursor in flyback: no strobe; sweep pulses, marker and channel step
    wr(ADDR_CURSOR, {24'h0, ~8'd150});
    tick(3);
    ch = o_chan_sel;
    nm = 0;
    ns = 0;
    nt = 0;
    repeat (2 * SWEEP)
    begin
      @(posedge i_core_clk);
      #1;
      nm += (o_cursor_mark === 1'b1);
      ns += (o_sweep_sync === 1'b1);
      nt += (o_trig_mark === 1'b1);
    end
    chk32(nm, 0, "flyback strobe");
    chk32(ns, 2, "sweep pulses");
    chk32(nt, 2 * RDIV, "trigger marker");
    chk32({29'h0, o_chan_sel}, {29'h0, ch + 3'd2}, "channel step");
    $display("test flyback done");

    // Abort straight after arming
    wr(ADDR_CMD, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0002);
    tick(3);
    chk1(o_recording, 1'b0, "abort");
    chk1(o_disp_blank, 1'b0, "abort unblank");
    $display("test abort done");
    give_verdict();
  end
endmodule : la_capture_bench
